// file: drive_state_status_mode_tb.sv
// testbench of the drive state and status block
// assumes the controller model as bus master and a 20 MHz clock
`include "dssm_consts.svh"
module drive_state_status_mode_tb
  import dssm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        volt_ok, target_reached, limit_active, drive_error;
  logic        velocity_mode, torque_on, irq;
  int          err_count, num_checks, cycles;
  logic [31:0] d;
  logic [7:0]  mode_val;       // mode value written and expected back
  logic [4:0]  seq_cmd [11];   // {reset, op, no qs, volt, on}
  logic [7:0]  seq_code [11];  // expected state code

  // ------------------------------------------------------------------
  // design and controller model
  // ------------------------------------------------------------------
  dssm_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .volt_ok(volt_ok), .target_reached(target_reached), .limit_active(limit_active),
    .drive_error(drive_error), .velocity_mode(velocity_mode), .torque_on(torque_on),
    .irq(irq));
  dssm_ctl_model u_ctl (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // clock and hang guard
  initial hclk = 1'b0;
  always #25 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      test_done();
    end
  end

  // one comparison
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // read a register and compare
  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string nm);
    u_ctl.bus_read(idx, d);
    chk(nm, d, exp);
  endtask

  // status word from a state code and the live drive inputs
  function automatic logic [31:0] expw(input logic [7:0] code);
    logic [31:0] w;
    w = {24'h000000, code};
    w[`DSSM_SW_VOLT] = volt_ok;
    w[`DSSM_SW_TGT]  = target_reached;
    w[`DSSM_SW_LIM]  = limit_active;
    return w;
  endfunction

  // poll the status word a bounded number of times, then compare
  task automatic wait_stat(input logic [7:0] code);
    d = ~expw(code);
    for (int i = 0; i < 40 && d !== expw(code); i++)
      u_ctl.bus_read(`DSSM_IDX_STATUS, d);
    chk("status", d, expw(code));
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    volt_ok = 1'b1;
    target_reached = 1'b0;
    limit_active = 1'b0;
    drive_error = 1'b0;
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    seq_cmd  = '{5'h06, 5'h07, 5'h0f, 5'h07, 5'h0f, 5'h0b, 5'h0f, 5'h06, 5'h07, 5'h06, 5'h00};
    seq_code = '{8'h21, 8'h23, 8'h27, 8'h23, 8'h27, 8'h07, 8'h27, 8'h21, 8'h23, 8'h21, 8'h60};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // after reset: switch-on disabled, profile off
    wait_stat(8'h60);
    rd_chk(`DSSM_IDX_MODE_SEL, 32'h0000_00ff, "sel");
    rd_chk(`DSSM_IDX_MODE_ECH, 32'h0000_00ff, "echo");
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("hready", {31'h0, hreadyout}, 32'h1);
    // every command but fault reset walked through the state chart
    for (int i = 0; i < 11; i++)
    begin
      u_ctl.command(seq_cmd[i]);
      wait_stat(seq_code[i]);
      @(posedge hclk);
      chk("torque", {31'h0, torque_on}, {31'h0, seq_code[i][2]});
    end
    // voltage flag follows the power circuit
    @(posedge hclk);
    volt_ok <= 1'b0;
    wait_stat(8'h60);
    @(posedge hclk);
    volt_ok <= 1'b1;
    // read-only status, unmapped place
    u_ctl.bus_write(`DSSM_IDX_STATUS, 32'hffff_ffff);
    wait_stat(8'h60);
    u_ctl.bus_write(16'h1000, 32'hffff_ffff);
    rd_chk(16'h1000, 32'h0000_0000, "unmapped");
    // both mode encodings; echo ignores writes
    u_ctl.bus_write(`DSSM_IDX_MODE_ECH, 32'h0000_0002);
    rd_chk(`DSSM_IDX_MODE_ECH, 32'h0000_00ff, "echo ro");
    for (int i = 0; i < 2; i++)
    begin
      mode_val = (i == 0) ? `DSSM_MODE_VEL : `DSSM_MODE_OFF;
      u_ctl.bus_write(`DSSM_IDX_MODE_SEL, {24'h0, mode_val});
      rd_chk(`DSSM_IDX_MODE_SEL, {24'h0, mode_val}, "sel");
      rd_chk(`DSSM_IDX_MODE_ECH, {24'h0, mode_val}, "echo");
      chk("velmode", {31'h0, velocity_mode}, {31'h0, i == 0});
    end
    // interrupts: mask to target only, clear, raise limit and target
    u_ctl.bus_write(`DSSM_IDX_IRQ_MASK, 32'h0000_0001);
    u_ctl.bus_write(`DSSM_IDX_IRQ_STAT, 32'h0000_000f);
    rd_chk(`DSSM_IDX_IRQ_STAT, 32'h0, "irq stat");
    @(posedge hclk);
    limit_active <= 1'b1;
    wait_stat(8'h60);
    chk("irq masked", {31'h0, irq}, 32'h0);
    target_reached <= 1'b1;
    wait_stat(8'h60);
    chk("irq", {31'h0, irq}, 32'h1);
    @(posedge hclk);
    target_reached <= 1'b0;
    limit_active <= 1'b0;
    rd_chk(`DSSM_IDX_IRQ_STAT, 32'h3, "irq stat");
    u_ctl.bus_write(`DSSM_IDX_IRQ_STAT, 32'h0000_0003);
    rd_chk(`DSSM_IDX_IRQ_STAT, 32'h0, "irq stat");
    chk("irq clr", {31'h0, irq}, 32'h0);
    // fault reaction, fault, fault reset
    @(posedge hclk);
    drive_error <= 1'b1;
    wait_stat(8'h2f);
    wait_stat(8'h28);
    @(posedge hclk);
    drive_error <= 1'b0;
    u_ctl.command(5'h10);
    wait_stat(8'h60);
    // reset again in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_stat(8'h60);
    test_done();
  end
endmodule

// file: dssm_consts.svh
// constants of the drive state and status block: offsets, fields, reset values, timing
// assumes a 20 MHz clock and a word-addressed AHB-Lite register map
`ifndef DSSM_CONSTS_SVH
`define DSSM_CONSTS_SVH

// ------------------------------------------------------------------
// register indices as printed; byte address is four times the index
// ------------------------------------------------------------------
`define DSSM_IDX_CMD      16'h6040
`define DSSM_IDX_STATUS   16'h6041
`define DSSM_IDX_MODE_SEL 16'h6060
`define DSSM_IDX_MODE_ECH 16'h6061
`define DSSM_IDX_IRQ_STAT 16'h7000
`define DSSM_IDX_IRQ_MASK 16'h7001
`define DSSM_IDX_CTRL     16'h7002

// ------------------------------------------------------------------
// command word bit positions
// ------------------------------------------------------------------
`define DSSM_CW_SWON   0
`define DSSM_CW_ENVOLT 1
`define DSSM_CW_NOQS   2
`define DSSM_CW_ENOP   3
`define DSSM_CW_FRST   7

// ------------------------------------------------------------------
// status word bit positions
// ------------------------------------------------------------------
`define DSSM_SW_RTSO   0
`define DSSM_SW_SWON   1
`define DSSM_SW_OPEN   2
`define DSSM_SW_FAULT  3
`define DSSM_SW_VOLT   4
`define DSSM_SW_NOQS   5
`define DSSM_SW_SOD    6
`define DSSM_SW_TGT    10
`define DSSM_SW_LIM    11

// ------------------------------------------------------------------
// mode encodings and reset values
// ------------------------------------------------------------------
`define DSSM_MODE_OFF  8'hff
`define DSSM_MODE_VEL  8'h02
`define DSSM_MODE_RST  8'hff
`define DSSM_CTRL_RST  4'h0

// ------------------------------------------------------------------
// timing: fault reaction duration
// ------------------------------------------------------------------
`define DSSM_CLK_NS     50
`define DSSM_FREACT_NS  1000
`define DSSM_FREACT_CYC ((`DSSM_FREACT_NS + `DSSM_CLK_NS - 1) / `DSSM_CLK_NS)

`endif

// file: dssm_ctl_model.sv
// controller-side model: an AHB-Lite master that writes command words
// assumes one slave whose hreadyout comes back as hready
`include "dssm_consts.svh"
module dssm_ctl_model
  import dssm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------------
  // idle bus at time zero
  // ------------------------------------------------------------------
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // one single word transfer; released lines show inverted junk
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    // address phase held until hready seen high
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= w ? wd : ~hwdata;
    // data phase held until hready seen high
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~hwdata;
  endtask

  // register write
  task automatic bus_write(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] unused;
    xfer(1'b1, idx, wd, unused);
  endtask

  // register read
  task automatic bus_read(input logic [15:0] idx, output logic [31:0] rd);
    xfer(1'b0, idx, 32'h0000_0000, rd);
  endtask

  // command bit layout
  // f packs fault reset, enable operation, no quick stop, enable voltage, switch on
  task automatic command(input logic [4:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`DSSM_CW_SWON]   = f[0];
    w[`DSSM_CW_ENVOLT] = f[1];
    w[`DSSM_CW_NOQS]   = f[2];
    w[`DSSM_CW_ENOP]   = f[3];
    w[`DSSM_CW_FRST]   = f[4];
    bus_write(`DSSM_IDX_CMD, w);
  endtask
endmodule

// file: dssm_mode_mem.sv
// small memory of the mode select value and its echo
// assumes one clock, async active-low reset; read data come out of a register
`include "dssm_consts.svh"
module dssm_mode_mem
  import dssm_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] sel_q,
  output logic      [7:0] echo_q
);
  logic [7:0] sel_next; // next select value

  // ------------------------------------------------------------------
  // next value
  // ------------------------------------------------------------------
  always_comb
  begin
    sel_next = sel_q;
    if (wr_en)
    begin
      sel_next = wr_data;
    end
  end

  // ------------------------------------------------------------------
  // registers; echo follows select one cycle later
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sel_q  <= `DSSM_MODE_RST;
      echo_q <= `DSSM_MODE_RST;
    end
    else
    begin
      sel_q  <= sel_next;
      echo_q <= sel_q;
    end
  end
endmodule

// file: dssm_pkg.sv
// types of the drive state and status block
// assumes dssm_consts.svh supplies the numbers
package dssm_pkg;
  // ------------------------------------------------------------------
  // drive states
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    DSSM_NOT_READY,
    DSSM_SO_DISABLED,
    DSSM_READY,
    DSSM_SWITCHED_ON,
    DSSM_OP_ENABLED,
    DSSM_QSTOP,
    DSSM_FAULT_REACT,
    DSSM_FAULT
  } dssm_state_t;

  // ------------------------------------------------------------------
  // bus pending data phase
  // ------------------------------------------------------------------
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [15:0] index;
  } dssm_req_t;

  // ------------------------------------------------------------------
  // external drive conditions
  // ------------------------------------------------------------------
  typedef struct packed
  {
    logic volt_ok;
    logic target;
    logic limit;
    logic error;
  } dssm_cond_t;
endpackage

// file: dssm_top.sv
// drive state machine, status word, mode select and echo on AHB-Lite
// assumes one 20 MHz clock, async active-low reset, single word transfers
//
// What this block does
// - shutdown, switch-on, disable-voltage commands decoded
// - quick stop, disable/enable operation, fault reset
// - state shown in status bits 0,1,2,3,6
// - bit 4 follows power circuit voltage good
// - bit 5 high unless quick stop active
// - bit 10 target reached, bit 11 limit
// - not-ready and switch-on-disabled encodings
// - ready, switched-on, operation-enabled encodings
// - quick stop, fault reaction, fault encodings
// - status word read only, live state
// - mode select writable: -1 off, 2 velocity
// - velocity mode flag drives profile generation
// - mode echo mirrors the selected mode
// - fault reaction ends in fault state
`include "dssm_consts.svh"
module dssm_top
  import dssm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        volt_ok,
  input  wire logic        target_reached,
  input  wire logic        limit_active,
  input  wire logic        drive_error,
  output logic             velocity_mode,
  output logic             torque_on,
  output logic             irq
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  dssm_state_t state_reg, state_next;          // drive state
  logic [7:0]  cmd_reg, cmd_next;              // command word
  dssm_req_t   req_reg, req_next;              // pending data phase
  logic [31:0] rdata_reg, rdata_next;          // read data
  logic [3:0]  ist_reg, ist_next;              // sticky events
  logic [3:0]  imask_reg, imask_next;          // event mask
  logic        irq_reg, irq_next;              // interrupt out
  logic        vel_reg, vel_next;              // velocity mode out
  logic        tq_reg, tq_next;                // torque out
  logic [4:0]  frc_reg, frc_next;              // fault reaction count
  logic [15:0] status;                         // live status word
  dssm_cond_t  cond;                           // external conditions
  logic [3:0]  events;                         // state change pulse, error/limit/target levels
  logic        st_changed;                     // state changed pulse
  logic        mode_wr;                        // mode select write
  logic [7:0]  mode_sel;                       // stored select
  logic [7:0]  mode_echo;                      // stored echo

  assign cond = '{volt_ok: volt_ok, target: target_reached,
                  limit: limit_active, error: drive_error};

  // ------------------------------------------------------------------
  // status encoding per state
  // ------------------------------------------------------------------
  function automatic logic [6:0] state_bits(input dssm_state_t s);
    case (s)
      DSSM_NOT_READY:   state_bits = 7'b0100000;
      DSSM_SO_DISABLED: state_bits = 7'b1100000;
      DSSM_READY:       state_bits = 7'b0100001;
      DSSM_SWITCHED_ON: state_bits = 7'b0100011;
      DSSM_OP_ENABLED:  state_bits = 7'b0100111;
      DSSM_QSTOP:       state_bits = 7'b0000111;
      DSSM_FAULT_REACT: state_bits = 7'b0101111;
      default:          state_bits = 7'b0101000;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // status word assembly
  // ------------------------------------------------------------------
  always_comb
  begin
    status = 16'h0000;
    status[6:0] = state_bits(state_reg);
    status[`DSSM_SW_VOLT] = cond.volt_ok;
    status[`DSSM_SW_TGT] = cond.target;
    status[`DSSM_SW_LIM] = cond.limit;
  end

  // ------------------------------------------------------------------
  // state machine next value
  // ------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    frc_next   = frc_reg;
    case (state_reg)
      DSSM_NOT_READY:
        state_next = DSSM_SO_DISABLED;
      DSSM_SO_DISABLED:
        if (!cmd_reg[`DSSM_CW_FRST] && cmd_reg[`DSSM_CW_NOQS] &&
            cmd_reg[`DSSM_CW_ENVOLT] && !cmd_reg[`DSSM_CW_SWON])
          state_next = DSSM_READY;
      DSSM_READY:
        if (!cmd_reg[`DSSM_CW_ENVOLT] || !cmd_reg[`DSSM_CW_NOQS])
          state_next = DSSM_SO_DISABLED;
        else if (cmd_reg[`DSSM_CW_SWON] && !cmd_reg[`DSSM_CW_ENOP] && cond.volt_ok)
          state_next = DSSM_SWITCHED_ON;
      DSSM_SWITCHED_ON:
        if (!cmd_reg[`DSSM_CW_ENVOLT] || !cmd_reg[`DSSM_CW_NOQS])
          state_next = DSSM_SO_DISABLED;
        else if (!cmd_reg[`DSSM_CW_SWON])
          state_next = DSSM_READY;
        else if (cmd_reg[`DSSM_CW_ENOP])
          state_next = DSSM_OP_ENABLED;
      DSSM_OP_ENABLED:
        if (!cmd_reg[`DSSM_CW_ENVOLT])
          state_next = DSSM_SO_DISABLED;
        else if (!cmd_reg[`DSSM_CW_NOQS])
          state_next = DSSM_QSTOP;
        else if (!cmd_reg[`DSSM_CW_SWON])
          state_next = DSSM_READY;
        else if (!cmd_reg[`DSSM_CW_ENOP])
          state_next = DSSM_SWITCHED_ON;
      DSSM_QSTOP:
        if (!cmd_reg[`DSSM_CW_ENVOLT])
          state_next = DSSM_SO_DISABLED;
        else if (cmd_reg[3:0] == 4'hf)
          state_next = DSSM_OP_ENABLED;
      DSSM_FAULT_REACT:
      begin
        if (frc_reg == 5'(`DSSM_FREACT_CYC - 1))
          state_next = DSSM_FAULT;
        else
          frc_next = frc_reg + 5'h01;
      end
      default:
        if (cmd_reg[`DSSM_CW_FRST] && !cond.error)
          state_next = DSSM_SO_DISABLED;
    endcase
    if (cond.error && state_reg != DSSM_FAULT_REACT && state_reg != DSSM_FAULT)
    begin
      state_next = DSSM_FAULT_REACT;
      frc_next   = 5'h00;
    end
  end

  // ------------------------------------------------------------------
  // bus slave next values
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [15:0] idx;
    idx        = haddr[17:2];
    req_next   = '{valid: 1'b0, write: 1'b0, index: 16'h0000};
    cmd_next   = cmd_reg;
    rdata_next = rdata_reg;
    imask_next = imask_reg;
    mode_wr    = 1'b0;
    st_changed = (state_next != state_reg);
    events     = {st_changed, cond.error, cond.limit, cond.target};
    // sets win over write-one clears
    ist_next   = ist_reg;
    if (hsel && hready && htrans[1])
    begin
      req_next = '{valid: 1'b1, write: hwrite, index: idx};
      if (idx == `DSSM_IDX_STATUS)
        rdata_next = {16'h0000, status};
      else if (idx == `DSSM_IDX_CMD)
        rdata_next = {24'h000000, cmd_reg};
      else if (idx == `DSSM_IDX_MODE_ECH)
        rdata_next = {24'h000000, mode_echo};
      else if (idx == `DSSM_IDX_MODE_SEL)
        rdata_next = {24'h000000, mode_sel};
      else if (idx == `DSSM_IDX_IRQ_STAT)
        rdata_next = {28'h0000000, ist_reg};
      else if (idx == `DSSM_IDX_IRQ_MASK)
        rdata_next = {28'h0000000, imask_reg};
      else
        rdata_next = 32'h00000000;
    end
    if (req_reg.valid && req_reg.write)
    begin
      if (req_reg.index == `DSSM_IDX_CMD)
        cmd_next = hwdata[7:0];
      else if (req_reg.index == `DSSM_IDX_MODE_SEL)
        mode_wr = 1'b1;
      else if (req_reg.index == `DSSM_IDX_IRQ_STAT)
        ist_next = ist_reg & ~hwdata[3:0];
      else if (req_reg.index == `DSSM_IDX_IRQ_MASK)
        imask_next = hwdata[3:0];
    end
    ist_next = ist_next | events;
    irq_next = |(ist_next & imask_next);
    vel_next = (mode_echo == `DSSM_MODE_VEL);
    tq_next  = (state_next == DSSM_OP_ENABLED) || (state_next == DSSM_QSTOP);
  end

  // ------------------------------------------------------------------
  // mode select memory
  // ------------------------------------------------------------------
  dssm_mode_mem u_mode
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (mode_wr),
    .wr_data (hwdata[7:0]),
    .sel_q   (mode_sel),
    .echo_q  (mode_echo)
  );

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= DSSM_NOT_READY;
      cmd_reg   <= 8'h00;
      req_reg   <= '0;
      rdata_reg <= 32'h00000000;
      ist_reg   <= `DSSM_CTRL_RST;
      imask_reg <= `DSSM_CTRL_RST;
      irq_reg   <= 1'b0;
      vel_reg   <= 1'b0;
      tq_reg    <= 1'b0;
      frc_reg   <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      req_reg   <= req_next;
      rdata_reg <= rdata_next;
      ist_reg   <= ist_next;
      imask_reg <= imask_next;
      irq_reg   <= irq_next;
      vel_reg   <= vel_next;
      tq_reg    <= tq_next;
      frc_reg   <= frc_next;
    end
  end

  assign hrdata        = rdata_reg;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign irq           = irq_reg;
  assign velocity_mode = vel_reg;
  assign torque_on     = tq_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_freact_enter;
    state_reg != DSSM_FAULT_REACT ##1 state_reg == DSSM_FAULT_REACT;
  endsequence

  property p_freact_done;
    @(posedge hclk) disable iff (!hresetn)
      s_freact_enter |-> ##(`DSSM_FREACT_CYC) state_reg == DSSM_FAULT;
  endproperty
  a_freact_done: assert property (p_freact_done) else $error("fault reaction overran");

  property p_low_zero;
    @(posedge hclk) disable iff (!hresetn)
      status[9:7] == 3'h0 && status[15:12] == 4'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("undefined status bits set");

  property p_volt;
    @(posedge hclk) disable iff (!hresetn) status[`DSSM_SW_VOLT] == volt_ok;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage bit wrong");

  property p_noqs;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == DSSM_QSTOP) ? {status[6:5], status[3:0]} == 6'h07 : status[`DSSM_SW_NOQS];
  endproperty
  a_noqs: assert property (p_noqs) else $error("quick stop code wrong");

  property p_opcode;
    @(posedge hclk) disable iff (!hresetn)
      (state_reg == DSSM_OP_ENABLED) |-> status[6:5] == 2'b01 && status[3:0] == 4'h7;
  endproperty
  a_opcode: assert property (p_opcode) else $error("operation code wrong");

  property p_shutdown;
    @(posedge hclk) disable iff (!hresetn)
      state_reg == DSSM_SO_DISABLED && cmd_reg == 8'h06 && !drive_error
        |=> state_reg == DSSM_READY;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not taken");

  property p_enop;
    @(posedge hclk) disable iff (!hresetn)
      state_reg == DSSM_SWITCHED_ON && cmd_reg == 8'h0f && !drive_error
        |=> state_reg == DSSM_OP_ENABLED && torque_on;
  endproperty
  a_enop: assert property (p_enop) else $error("enable operation not taken");

  property p_echo;
    @(posedge hclk) disable iff (!hresetn) ##1 mode_echo == $past(mode_sel);
  endproperty
  a_echo: assert property (p_echo) else $error("echo does not mirror select");

  property p_tgt;
    @(posedge hclk) disable iff (!hresetn)
      status[`DSSM_SW_TGT] == target_reached && status[`DSSM_SW_LIM] == limit_active;
  endproperty
  a_tgt: assert property (p_tgt) else $error("target or limit bit wrong");
endmodule
